// ---- verilog/uml_consts.svh ----
// uml_consts.svh: register indices, field positions, reset values, counts
// assumes: included by bare name; indices are word indices on the bus
`ifndef UML_CONSTS_SVH
`define UML_CONSTS_SVH

// register word indices; byte address is four times the index
`define UML_IDX_DATA     4'h0
`define UML_IDX_IEN      4'h1
`define UML_IDX_IID      4'h2
`define UML_IDX_LCTL     4'h3
`define UML_IDX_MCTL     4'h4
`define UML_IDX_LSTAT    4'h5
`define UML_IDX_MSTAT    4'h6
`define UML_IDX_SCRATCH  4'h7
`define UML_IDX_DIV_LO   4'h0
`define UML_IDX_DIV_HI   4'h1

// modem control field positions
`define UML_MCTL_TRDY    0
`define UML_MCTL_RSEND   1
`define UML_MCTL_OUTA    2
`define UML_MCTL_OUTB    3
`define UML_MCTL_LOOP    4

// fifo control field positions
`define UML_FCTL_EN      0
`define UML_FCTL_RXCLR   1
`define UML_FCTL_TXCLR   2

// reset and idle values
`define UML_DIV_RST      16'h0001
`define UML_IID_IDLE     6'h01

// 16x tick counts: last tick of a bit, of 1.5 stop bits, of 2 stop bits
`define UML_T_BIT_LAST   5'h0F
`define UML_T_STOP15     5'h17
`define UML_T_STOP2      5'h1F
`define UML_RX_MID       4'h7
`define UML_RX_LAST      4'hF

`endif

// ---- verilog/uml_pkg.sv ----
// uml_pkg.sv: types and shared frame arithmetic for the uart core
// assumes: nothing outside itself
package uml_pkg;

	// line control layout, bit 7 down to bit 0
	typedef struct packed {
		logic       divisor_access_bit;
		logic       brk;
		logic       stick;
		logic       eps;
		logic       pen;
		logic       stb;
		logic [1:0] wls;
	} uml_lctl_t;

	// one received character with its error flags
	typedef struct packed {
		logic       brk;
		logic       fe;
		logic       pe;
		logic [7:0] data;
	} uml_rxres_t;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_DATA  = 3'b010,
		TX_PAR   = 3'b011,
		TX_STOP  = 3'b100
	} uml_tx_st_t;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_PAR   = 3'b011,
		RX_STOP  = 3'b100
	} uml_rx_st_t;

	// keep only the bits of the programmed word length
	function automatic logic [7:0] uml_mask(input logic [7:0] d,
		input logic [1:0] wls);
		uml_mask = d & (8'hFF >> (2'h3 - wls));
	endfunction

	// index of the last data bit, 4 to 7
	function automatic logic [2:0] uml_last(input logic [1:0] wls);
		uml_last = 3'h4 + {1'b0, wls};
	endfunction

	// parity bit for masked data; stick mode sends the inverse of eps
	function automatic logic uml_par(input logic [7:0] d,
		input uml_lctl_t l);
		uml_par = l.stick ? ~l.eps : ((^d) ^ ~l.eps);
	endfunction

endpackage

// ---- verilog/uml_fifo.sv ----
// uml_fifo.sv: synchronous flop fifo, valid/ready on both sides
// assumes: DEPTH is a power of two; one clock; clear is synchronous
`timescale 1ns/1ps
`default_nettype none

module uml_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             clear,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output var  logic             in_ready,
	output var  logic [WIDTH-1:0] out_data,
	output var  logic             out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;

	// full and empty come from the count, so they are never stale
	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;
	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rp_r];

	// pointers and count; storage itself needs no reset
	always_ff @(posedge clk)
	begin
		if (!reset_n || clear)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wp_r  <= wp_r + AW'(push);
			rp_r  <= rp_r + AW'(pop);
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem_r[wp_r] <= in_data;
	end

endmodule
`default_nettype wire

// ---- verilog/uml_rx.sv ----
// uml_rx.sv: serial receiver clocked by 16x ticks
// assumes: rxd and tick already synchronised to clk; tick one cycle wide
`timescale 1ns/1ps
`default_nettype none
`include "uml_consts.svh"

module uml_rx
(
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic                 clear,
	input  wire logic                 tick,
	input  wire logic                 rxd,
	input  wire uml_pkg::uml_lctl_t   lctl,
	output var  uml_pkg::uml_rxres_t  res,
	output var  logic                 res_valid
);
	uml_pkg::uml_rx_st_t st_r;
	logic [3:0] cnt_r;
	logic [2:0] bit_r;
	logic [7:0] sh_r;
	logic       pe_r;
	logic       pbit_r;

	wire last = (cnt_r == `UML_RX_LAST);

	// start verified at mid bit, then each bit sampled 16 ticks later
	always_ff @(posedge clk)
	begin
		if (!reset_n || clear)
		begin
			st_r      <= uml_pkg::RX_IDLE;
			cnt_r     <= 4'h0;
			bit_r     <= 3'h0;
			sh_r      <= 8'h00;
			pe_r      <= 1'b0;
			pbit_r    <= 1'b0;
			res       <= '0;
			res_valid <= 1'b0;
		end
		else
		begin
			res_valid <= 1'b0;
			if (tick)
			begin
				cnt_r <= cnt_r + 4'h1;
				unique case (st_r)
				uml_pkg::RX_IDLE:
					if (!rxd)
					begin
						st_r  <= uml_pkg::RX_START;
						cnt_r <= 4'h0;
					end
				uml_pkg::RX_START:
					if (cnt_r == `UML_RX_MID)
					begin
						// a glitch shorter than half a bit is dropped
						st_r   <= rxd ? uml_pkg::RX_IDLE : uml_pkg::RX_DATA;
						cnt_r  <= 4'h0;
						bit_r  <= 3'h0;
						sh_r   <= 8'h00;
						pe_r   <= 1'b0;
						pbit_r <= 1'b0;
					end
				uml_pkg::RX_DATA:
					if (last)
					begin
						sh_r[bit_r] <= rxd;
						if (bit_r == uml_pkg::uml_last(lctl.wls))
							st_r <= lctl.pen ? uml_pkg::RX_PAR
								: uml_pkg::RX_STOP;
						else
							bit_r <= bit_r + 3'h1;
					end
				uml_pkg::RX_PAR:
					if (last)
					begin
						pbit_r <= rxd;
						pe_r   <= rxd != uml_pkg::uml_par(sh_r, lctl);
						st_r   <= uml_pkg::RX_STOP;
					end
				uml_pkg::RX_STOP:
					if (last)
					begin
						res.data  <= sh_r;
						res.pe    <= pe_r;
						res.fe    <= ~rxd;
						res.brk   <= (sh_r == 8'h00) & ~pbit_r & ~rxd;
						res_valid <= 1'b1;
						st_r      <= uml_pkg::RX_IDLE;
					end
				default:
					st_r <= uml_pkg::RX_IDLE;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// ---- verilog/uml_top.sv ----
// uml_top.sv: uart core with modem handshake pins, baud generator and
// an Avalon-MM register slave; transmit data pass a 16-word fifo
// assumes: clk is the reference oscillator; every pin but reset_n and the bus is asynchronous
//
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "uml_consts.svh"

module uml_top
#(
	parameter int          FIFO_DEPTH = 16,
	parameter logic [15:0] DIV_RESET  = `UML_DIV_RST
)
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	input  wire logic        master_reset_in,
	input  wire logic        serial_rx_in,
	input  wire logic        rx_clock16,
	input  wire logic        cts_n,
	input  wire logic        dsr_n,
	input  wire logic        ri_n,
	input  wire logic        dcd_n,
	output var  logic        serial_tx_out,
	output var  logic        rts_n,
	output var  logic        dtr_n,
	output var  logic        user_output_a_n,
	output var  logic        user_output_b_n,
	output var  logic        tx_rate_clock_out
);

////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; the first stage feeds only the second
	logic       mr_s1_r;
	logic       mr_s2_r;
	logic [2:0] rck_r;
	logic [1:0] rxd_r;
	logic [3:0] mod_s1_r;
	logic [3:0] mod_s2_r;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			mr_s1_r  <= 1'b0;
			mr_s2_r  <= 1'b0;
			rck_r    <= 3'h0;
			rxd_r    <= 2'h3;
			mod_s1_r <= 4'hF;
			mod_s2_r <= 4'hF;
		end
		else
		begin
			mr_s1_r  <= master_reset_in;
			mr_s2_r  <= mr_s1_r;
			rck_r    <= {rck_r[1:0], rx_clock16};
			rxd_r    <= {rxd_r[0], serial_rx_in};
			mod_s1_r <= {dcd_n, ri_n, dsr_n, cts_n};
			mod_s2_r <= mod_s1_r;
		end
	end

	// master reset acts as a synchronous clear of the control state
	wire clr     = ~reset_n | mr_s2_r;
	wire rx_tick = rck_r[1] & ~rck_r[2];

////////////////////////////////////////////////////////////////////////////
	// programmable registers
	uml_pkg::uml_lctl_t lctl_r;
	logic [3:0]  ien_r;
	logic [4:0]  mctl_r;
	logic [7:0]  scr_r;
	logic        fen_r;
	logic [15:0] div_r;
	logic        wait_r;

	wire loop = mctl_r[`UML_MCTL_LOOP];
	wire divisor_access_bit = lctl_r.divisor_access_bit;
	wire a_data = ~divisor_access_bit & (avs_address == `UML_IDX_DATA);
	wire a_dlo  = divisor_access_bit & (avs_address == `UML_IDX_DIV_LO);
	wire a_dhi  = divisor_access_bit & (avs_address == `UML_IDX_DIV_HI);
	wire a_ien  = ~divisor_access_bit & (avs_address == `UML_IDX_IEN);
	wire a_iid  = (avs_address == `UML_IDX_IID);
	wire a_lctl = (avs_address == `UML_IDX_LCTL);
	wire a_mctl = (avs_address == `UML_IDX_MCTL);
	wire a_lst  = (avs_address == `UML_IDX_LSTAT);
	wire a_mst  = (avs_address == `UML_IDX_MSTAT);
	wire a_scr  = (avs_address == `UML_IDX_SCRATCH);

	// a request is answered one cycle after it is seen; a transmit write
	// into a full fifo keeps waitrequest high until a word leaves
	logic txq_in_ready;
	wire req    = avs_read | avs_write;
	wire commit = req & ~wait_r;
	wire thr_wr = avs_write & avs_byteenable[0] & a_data;
	wire go     = req & wait_r & ~(thr_wr & ~txq_in_ready);
	wire wr_ok  = commit & avs_write & avs_byteenable[0];
	wire rd_ok  = commit & avs_read;
	wire [7:0] wd = avs_writedata[7:0];
	wire tx_clr = wr_ok & a_iid & wd[`UML_FCTL_TXCLR];
	wire rx_clr = wr_ok & a_iid & wd[`UML_FCTL_RXCLR];

	// control registers; master reset clears all but the divisor
	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			lctl_r <= '0;
			ien_r  <= 4'h0;
			mctl_r <= 5'h00;
			scr_r  <= 8'h00;
			fen_r  <= 1'b0;
		end
		else if (wr_ok)
		begin
			if (a_lctl)
				lctl_r <= uml_pkg::uml_lctl_t'(wd);
			if (a_ien)
				ien_r <= wd[3:0];
			if (a_mctl)
				mctl_r <= wd[4:0];
			if (a_scr)
				scr_r <= wd;
			if (a_iid)
				fen_r <= wd[`UML_FCTL_EN];
		end
	end

	// divisor survives master reset, only the system reset loads it
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			div_r <= DIV_RESET;
		else if (wr_ok & a_dlo)
			div_r[7:0] <= wd;
		else if (wr_ok & a_dhi)
			div_r[15:8] <= wd;
	end

////////////////////////////////////////////////////////////////////////////
	// receive side: holding register and line status flags
	uml_pkg::uml_rxres_t rx_res;
	logic       rx_ok;
	logic [7:0] rbr_r;
	logic       dr_r;
	logic       oe_r;
	logic       pe_r;
	logic       fe_r;
	logic       bi_r;
	logic       tx_line;

	wire rd_rbr = rd_ok & a_data;
	wire rd_lst = rd_ok & a_lst;

	uml_rx u_rx (
		.clk       (clk),
		.reset_n   (reset_n),
		.clear     (mr_s2_r),
		.tick      (rx_tick),
		.rxd       (loop ? tx_line : rxd_r[1]),
		.lctl      (lctl_r),
		.res       (rx_res),
		.res_valid (rx_ok)
	);

	// flags: an arriving character wins over a same-cycle read or rx clear
	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			dr_r <= 1'b0;
			oe_r <= 1'b0;
			pe_r <= 1'b0;
			fe_r <= 1'b0;
			bi_r <= 1'b0;
		end
		else
		begin
			dr_r <= rx_ok | (dr_r & ~rd_rbr & ~rx_clr);
			oe_r <= (rx_ok & dr_r) | (oe_r & ~rd_lst);
			pe_r <= (rx_ok & rx_res.pe) | (pe_r & ~rd_lst);
			fe_r <= (rx_ok & rx_res.fe) | (fe_r & ~rd_lst);
			bi_r <= (rx_ok & rx_res.brk) | (bi_r & ~rd_lst);
		end
	end

	// data holding register is kept across master reset
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			rbr_r <= 8'h00;
		else if (rx_ok)
			rbr_r <= rx_res.data;
	end

////////////////////////////////////////////////////////////////////////////
	// modem status: live levels complemented, loop feeds back the outputs
	logic [3:0] mprev_r;
	logic [3:0] mdel_r;
	logic       minit_r;

	wire [3:0] mhi = loop
		? {mctl_r[`UML_MCTL_OUTB], mctl_r[`UML_MCTL_OUTA],
		   mctl_r[`UML_MCTL_TRDY], mctl_r[`UML_MCTL_RSEND]}
		: ~mod_s2_r;
	// ring delta flags only the end of a ring, as the level drops
	wire [3:0] mchg = {4{minit_r}} & {mhi[3] ^ mprev_r[3],
		mprev_r[2] & ~mhi[2], mhi[1] ^ mprev_r[1], mhi[0] ^ mprev_r[0]};
	wire rd_mst = rd_ok & a_mst;

	// first cycle after reset only primes the history, no false deltas
	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			mprev_r <= 4'h0;
			mdel_r  <= 4'h0;
			minit_r <= 1'b0;
		end
		else
		begin
			mprev_r <= mhi;
			mdel_r  <= mchg | (mdel_r & ~{4{rd_mst}});
			minit_r <= 1'b1;
		end
	end

////////////////////////////////////////////////////////////////////////////
	// baud generator: one 16x tick every div clk cycles, zero acts as one
	logic [15:0] bcnt_r;
	wire [15:0] div_eff = (div_r == 16'h0000) ? 16'h0001 : div_r;
	wire        btick   = (bcnt_r >= div_eff - 16'h0001);

	always_ff @(posedge clk)
	begin
		if (clr)
			bcnt_r <= 16'h0000;
		else
			bcnt_r <= btick ? 16'h0000 : bcnt_r + 16'h0001;
	end

////////////////////////////////////////////////////////////////////////////
	// transmit fifo; back-pressure reaches the bus through waitrequest
	logic [7:0] txq_data;
	logic       txq_valid;
	uml_pkg::uml_tx_st_t tx_st_r;
	uml_pkg::uml_tx_st_t tx_st_nxt;

	uml_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_txq (
		.clk       (clk),
		.reset_n   (reset_n),
		.clear     (mr_s2_r | tx_clr),
		.in_data   (wd),
		.in_valid  (wr_ok & a_data),
		.in_ready  (txq_in_ready),
		.out_data  (txq_data),
		.out_valid (txq_valid),
		.out_ready (tx_st_r == uml_pkg::TX_IDLE)
	);

	// transmitter: 16 ticks per bit, 1, 1.5 or 2 stop bits
	logic [4:0] tcnt_r;
	logic [4:0] tcnt_nxt;
	logic [2:0] tbit_r;
	logic [2:0] tbit_nxt;
	logic [7:0] tsh_r;

	wire [4:0] stop_last = ~lctl_r.stb ? `UML_T_BIT_LAST
		: (lctl_r.wls == 2'h0) ? `UML_T_STOP15 : `UML_T_STOP2;
	wire tend = btick & (tcnt_r == `UML_T_BIT_LAST);
	wire tpar = uml_pkg::uml_par(tsh_r, lctl_r);
	assign tx_line = (tx_st_r == uml_pkg::TX_START) ? 1'b0
		: (tx_st_r == uml_pkg::TX_DATA) ? tsh_r[tbit_r]
		: (tx_st_r == uml_pkg::TX_PAR) ? tpar : 1'b1;
	wire temt = ~txq_valid & (tx_st_r == uml_pkg::TX_IDLE);

	always_comb
	begin
		tx_st_nxt = tx_st_r;
		tcnt_nxt  = btick ? tcnt_r + 5'h01 : tcnt_r;
		tbit_nxt  = tbit_r;
		unique case (tx_st_r)
		uml_pkg::TX_IDLE:
		begin
			tcnt_nxt = 5'h00;
			if (txq_valid)
				tx_st_nxt = uml_pkg::TX_START;
		end
		uml_pkg::TX_START:
			if (tend)
			begin
				tx_st_nxt = uml_pkg::TX_DATA;
				tcnt_nxt  = 5'h00;
				tbit_nxt  = 3'h0;
			end
		uml_pkg::TX_DATA:
			if (tend)
			begin
				tcnt_nxt = 5'h00;
				if (tbit_r == uml_pkg::uml_last(lctl_r.wls))
					tx_st_nxt = lctl_r.pen ? uml_pkg::TX_PAR
						: uml_pkg::TX_STOP;
				else
					tbit_nxt = tbit_r + 3'h1;
			end
		uml_pkg::TX_PAR:
			if (tend)
			begin
				tx_st_nxt = uml_pkg::TX_STOP;
				tcnt_nxt  = 5'h00;
			end
		uml_pkg::TX_STOP:
			if (btick && tcnt_r == stop_last)
				tx_st_nxt = uml_pkg::TX_IDLE;
		default:
			tx_st_nxt = uml_pkg::TX_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			tx_st_r <= uml_pkg::TX_IDLE;
			tcnt_r  <= 5'h00;
			tbit_r  <= 3'h0;
			tsh_r   <= 8'h00;
		end
		else
		begin
			tx_st_r <= tx_st_nxt;
			tcnt_r  <= tcnt_nxt;
			tbit_r  <= tbit_nxt;
			if (tx_st_r == uml_pkg::TX_IDLE && txq_valid)
				tsh_r <= uml_pkg::uml_mask(txq_data, lctl_r.wls);
		end
	end

////////////////////////////////////////////////////////////////////////////
	// register read mux
	wire [7:0] lstat = {1'b0, temt, ~txq_valid, bi_r, fe_r, pe_r, oe_r,
		dr_r};
	wire [7:0] rd_mux =
		a_data ? rbr_r :
		a_dlo  ? div_r[7:0] :
		a_dhi  ? div_r[15:8] :
		a_ien  ? {4'h0, ien_r} :
		a_iid  ? {{2{fen_r}}, `UML_IID_IDLE} :
		a_lctl ? lctl_r :
		a_mctl ? {3'h0, mctl_r} :
		a_lst  ? lstat :
		a_mst  ? {mhi, mdel_r} :
		a_scr  ? scr_r : 8'h00;

	// bus answer; indices 8 to 15 read zero and ignore writes
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			wait_r       <= 1'b1;
			avs_readdata <= 32'h00000000;
		end
		else
		begin
			wait_r <= commit | (wait_r & ~go);
			if (go)
				avs_readdata <= {24'h000000, rd_mux};
		end
	end
	assign avs_waitrequest = wait_r;

	// pins; a reset or loop forces the serial and handshake lines to their idle high level
	wire force_hi = mr_s2_r | loop;
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			serial_tx_out     <= 1'b1;
			rts_n             <= 1'b1;
			dtr_n             <= 1'b1;
			user_output_a_n   <= 1'b1;
			user_output_b_n   <= 1'b1;
			tx_rate_clock_out <= 1'b0;
		end
		else
		begin
			serial_tx_out   <= force_hi | (~lctl_r.brk & tx_line);
			rts_n   <= force_hi | ~mctl_r[`UML_MCTL_RSEND];
			dtr_n   <= force_hi | ~mctl_r[`UML_MCTL_TRDY];
			user_output_a_n <= force_hi | ~mctl_r[`UML_MCTL_OUTA];
			user_output_b_n <= force_hi | ~mctl_r[`UML_MCTL_OUTB];
			tx_rate_clock_out <= btick;
		end
	end

endmodule
`default_nettype wire

// ---- test/uml_top_asserts.sv ----
// uml_top_asserts.sv: pin-level checks on the uart core
// assumes: bound into uml_top; bus master follows Avalon-MM
`timescale 1ns/1ps
`default_nettype none

module uml_top_chk
#(
	parameter logic [15:0] DIV_RESET  = 16'h0001
)
(
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        master_reset_in,
	input wire logic        cts_n,
	input wire logic        dsr_n,
	input wire logic        ri_n,
	input wire logic        dcd_n,
	input wire logic        serial_tx_out,
	input wire logic        rts_n,
	input wire logic        dtr_n,
	input wire logic        user_output_a_n,
	input wire logic        user_output_b_n,
	input wire logic        tx_rate_clock_out
);
	logic [4:0]  mcr_r;
	logic        divisor_access_bit_r;
	logic [15:0] div_r;
	logic [15:0] gap_r;
	logic [7:0]  age_r;
	logic [3:0]  lines_r;
	logic [2:0]  quiet_r;

	// shadows clear on the raw reset pin, ahead of its sync lag
	wire logic       wr_ok  = avs_write && !avs_waitrequest &&
		avs_byteenable[0];
	wire logic       clr    = !reset_n || master_reset_in;
	wire logic       div_wr = wr_ok && divisor_access_bit_r && avs_address[3:1] == 3'h0;
	wire logic [3:0] lines  = {dcd_n, ri_n, dsr_n, cts_n};

	// shadow of modem control and the divisor access bit
	always_ff @(posedge clk)
	begin
		if (clr)
			{mcr_r, divisor_access_bit_r} <= 6'h00;
		else if (wr_ok && avs_address == 4'h4)
			mcr_r <= avs_writedata[4:0];
		else if (wr_ok && avs_address == 4'h3)
			divisor_access_bit_r <= avs_writedata[7];
	end

	// divisor shadow survives master reset
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			div_r <= DIV_RESET;
		else if (div_wr)
			div_r <= avs_address[0] ? {avs_writedata[7:0], div_r[7:0]} :
				{div_r[15:8], avs_writedata[7:0]};
	end

	// age of the divisor, gap between rate pulses, quiet time of lines
	always_ff @(posedge clk)
	begin
		age_r   <= (clr || div_wr) ? 8'h00 :
			age_r + {7'h00, age_r != 8'hFF};
		gap_r   <= (!reset_n || tx_rate_clock_out) ? 16'h0000 :
			gap_r + 16'h0001;
		quiet_r <= (!reset_n || lines != lines_r) ? 3'h0 :
			quiet_r + {2'h0, quiet_r != 3'h7};
		lines_r <= lines;
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// five samples cover the two-flop pin sync plus the output flop
	sequence mr_held;
		master_reset_in [*5];
	endsequence
	sequence mcr_upd;
		(wr_ok && avs_address == 4'h4 && !master_reset_in) ##1
			!master_reset_in [*3];
	endsequence
	sequence msr_rd;
		avs_read && !avs_waitrequest && avs_address == 4'h6 && !mcr_r[4] &&
			quiet_r == 3'h7;
	endsequence

	tx_mr_high_a: assert property (mr_held |-> serial_tx_out)
		else $error("serial output low in reset");
	hs_mr_high_a: assert property
		(mr_held |-> rts_n && dtr_n && user_output_a_n && user_output_b_n)
		else $error("handshake pin low in reset");
	rts_follow_a: assert property
		(mcr_upd |-> rts_n == (!mcr_r[1] || mcr_r[4]))
		else $error("request-to-send pin wrong");
	dtr_follow_a: assert property
		(mcr_upd |-> dtr_n == (!mcr_r[0] || mcr_r[4]))
		else $error("terminal-ready pin wrong");
	user_follow_a: assert property
		(mcr_upd |-> user_output_a_n == (!mcr_r[2] || mcr_r[4]) &&
			user_output_b_n == (!mcr_r[3] || mcr_r[4]))
		else $error("user output pin wrong");
	msr_cts_a: assert property (msr_rd |-> avs_readdata[4] == !cts_n)
		else $error("status bit 4 wrong");
	msr_dsr_a: assert property (msr_rd |-> avs_readdata[5] == !dsr_n)
		else $error("status bit 5 wrong");
	msr_ri_a: assert property (msr_rd |-> avs_readdata[6] == !ri_n)
		else $error("status bit 6 wrong");
	msr_dcd_a: assert property (msr_rd |-> avs_readdata[7] == !dcd_n)
		else $error("status bit 7 wrong");
	baud_gap_a: assert property
		(tx_rate_clock_out && div_r > 16'h0001 && age_r == 8'hFF
			|-> gap_r == div_r - 16'h0001)
		else $error("rate pulse spacing wrong");
endmodule

bind uml_top uml_top_chk #(.DIV_RESET(DIV_RESET)) i_chk
(
	.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.master_reset_in(master_reset_in), .cts_n(cts_n), .dsr_n(dsr_n),
	.ri_n(ri_n), .dcd_n(dcd_n), .serial_tx_out(serial_tx_out), .rts_n(rts_n),
	.dtr_n(dtr_n), .user_output_a_n(user_output_a_n),
	.user_output_b_n(user_output_b_n), .tx_rate_clock_out(tx_rate_clock_out)
);
`default_nettype wire

// ---- test/uml_modem_model.sv ----
// uml_modem_model.sv: modem on the serial and handshake lines
// assumes: tasks are called just after a rising clk edge
`timescale 1ns/1ps
`default_nettype none

module uml_modem_model
(
	input  wire logic clk,
	input  wire logic serial_tx_out,
	input  wire logic tx_rate_clock_out,
	output var  logic serial_rx_in,
	output var  logic rx_clock16,
	output var  logic cts_n,
	output var  logic dsr_n,
	output var  logic ri_n,
	output var  logic dcd_n
);
	logic [7:0] cap_byte;
	logic [7:0] rx_q[$];

	// lines inactive; receive clock stands still outside frames
	initial
	begin
		{serial_rx_in, cts_n, dsr_n, ri_n, dcd_n} = 5'h1F;
		rx_clock16 = 1'b0;
	end

	task automatic set_lines(input logic [3:0] v);
		{dcd_n, ri_n, dsr_n, cts_n} <= v;
	endtask

	// one receive tick is four system clocks, well under clk/2
	task automatic tick();
		rx_clock16 <= 1'b1;
		repeat (2) @(posedge clk);
		rx_clock16 <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// start, eight data bits lsb first, stop; 16 ticks a bit
	task automatic send_byte(input logic [7:0] d);
		logic [9:0] fr;
		fr = {1'b1, d, 1'b0};
		for (int b = 0; b < 10; b++)
		begin
			serial_rx_in <= fr[b];
			repeat (16) tick();
		end
		repeat (4) tick();
	endtask

	task automatic wait_ticks(input int n);
		repeat (n)
		begin
			@(posedge clk);
			while (tx_rate_clock_out !== 1'b1)
				@(posedge clk);
		end
	endtask

	// capture frames mid-bit, paced by the 16x rate output
	initial
	begin
		forever
		begin
			@(negedge serial_tx_out);
			wait_ticks(8);
			for (int b = 0; b < 8; b++)
			begin
				wait_ticks(16);
				cap_byte[b] = serial_tx_out;
			end
			wait_ticks(16);
			rx_q.push_back(cap_byte);
		end
	end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// tb_top.sv: register-level test of the uart core and its modem pins
// assumes: design, checker and modem model compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
	begin \
		samples_checked++; \
		if ((gt) !== (ex)) \
		begin \
			$display("wrong value %s expected %h seen %h", nm, ex, gt); \
			num_errors++; \
		end \
	end

module tb_top;
	logic        clk, reset_n, avs_read, avs_write, avs_waitrequest;
	logic [3:0]  avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata;
	logic        master_reset_in, serial_rx_in, rx_clock16;
	logic        cts_n, dsr_n, ri_n, dcd_n, serial_tx_out, rts_n, dtr_n;
	logic        ua_n, ub_n, tx_rate_clock_out;
	logic [31:0] rq;
	int          num_errors, samples_checked, i, n;
	wire  [3:0]  hs = {ub_n, ua_n, rts_n, dtr_n};

	uml_top i_dut
	(
		.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.master_reset_in(master_reset_in), .serial_rx_in(serial_rx_in),
		.rx_clock16(rx_clock16), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
		.dcd_n(dcd_n), .serial_tx_out(serial_tx_out), .rts_n(rts_n),
		.dtr_n(dtr_n), .user_output_a_n(ua_n), .user_output_b_n(ub_n),
		.tx_rate_clock_out(tx_rate_clock_out)
	);
	uml_modem_model i_modem
	(
		.clk(clk), .serial_tx_out(serial_tx_out),
		.tx_rate_clock_out(tx_rate_clock_out), .serial_rx_in(serial_rx_in),
		.rx_clock16(rx_clock16), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
		.dcd_n(dcd_n)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// one Avalon access: hold until waitrequest is sampled low
	task automatic bus(input logic we, input logic [3:0] a,
		input logic [7:0] d);
		avs_address   <= a;
		avs_writedata <= {24'h000000, d};
		avs_write     <= we;
		avs_read      <= !we;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 4000);
		rq = avs_readdata;
		if (avs_waitrequest !== 1'b0)
		begin
			num_errors++;
			end_sim();
		end
		{avs_write, avs_read} <= 2'b00;
		@(posedge clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [3:0] a);
		bus(1'b0, a, 8'h00);
	endtask

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{reset_n, avs_read, avs_write, master_reset_in} = 4'h0;
		avs_address    = 4'h0;
		avs_writedata  = 32'h00000000;
		avs_byteenable = 4'hF;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		`CHK("pins", 5'h1F, {serial_tx_out, hs})
		rd(4'h5);
		`CHK("line status", 8'h60, rq)
		// all modem input levels
		for (i = 0; i < 16; i++)
		begin
			i_modem.set_lines(i[3:0]);
			repeat (8) @(posedge clk);
			rd(4'h6);
			`CHK("status lines", ~i[3:0], rq[7:4])
		end
		// all control patterns, then loop
		for (i = 0; i < 16; i++)
		begin
			wr(4'h4, i[7:0]);
			repeat (3) @(posedge clk);
			`CHK("control pins", ~i[3:0], hs)
		end
		wr(4'h4, 8'h1F);
		repeat (3) @(posedge clk);
		`CHK("loop pins", 4'hF, hs)
		wr(4'h4, 8'h00);
		// divisor only behind the access bit; unused index reads zero
		wr(4'h3, 8'h80);
		wr(4'h0, 8'h05);
		wr(4'h1, 8'h00);
		rd(4'h0);
		`CHK("divisor low", 8'h05, rq)
		wr(4'h3, 8'h03);
		wr(4'h1, 8'h0A);
		rd(4'h1);
		`CHK("enable reg", 8'h0A, rq)
		wr(4'h3, 8'h83);
		rd(4'h1);
		`CHK("divisor high", 8'h00, rq)
		wr(4'h3, 8'h03);
		wr(4'h9, 8'hFF);
		rd(4'h9);
		`CHK("unused index", 8'h00, rq)
		n = 0;
		repeat (100)
		begin
			@(posedge clk);
			n += (tx_rate_clock_out === 1'b1);
		end
		`CHK("rate pulses", 20, n)
		// overfill the transmit fifo; the last write stalls until room
		for (i = 0; i < 18; i++)
			wr(4'h0, 8'hA0 + i[7:0]);
		for (n = 0; i_modem.rx_q.size() < 18 && n < 30000; n++)
			@(posedge clk);
		if (n >= 30000)
		begin
			num_errors++;
			end_sim();
		end
		for (i = 0; i < 18; i++)
			`CHK("sent byte", 8'hA0 + i[7:0], i_modem.rx_q[i])
		i_modem.send_byte(8'h3C);
		rd(4'h5);
		`CHK("rx ready", 1'b1, rq[0])
		rd(4'h0);
		`CHK("rx byte", 8'h3C, rq)
		// master reset in mid-frame
		wr(4'h7, 8'h5A);
		wr(4'h4, 8'h0F);
		wr(4'h0, 8'h00);
		repeat (300) @(posedge clk);
		master_reset_in <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK("reset pins", 5'h1F, {serial_tx_out, hs})
		master_reset_in <= 1'b0;
		repeat (6) @(posedge clk);
		rd(4'h7);
		`CHK("scratch", 8'h00, rq)
		rd(4'h4);
		`CHK("modem ctl", 8'h00, rq)
		rd(4'h3);
		`CHK("line ctl", 8'h00, rq)
		rd(4'h5);
		`CHK("line status", 8'h60, rq)
		wr(4'h3, 8'h80);
		rd(4'h0);
		`CHK("divisor kept", 8'h05, rq)
		end_sim();
	end
endmodule
`default_nettype wire
